// ---- shared/tmm_pkg.sv ----
// constants, register map and link states for the temperature threshold monitor
package tmm_pkg;

   // ----------------------------------------------------------------
   // register pointers
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_TEMP = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h01;
   localparam logic [7:0] REG_HYST = 8'h02;
   localparam logic [7:0] REG_MAX = 8'h03;
   localparam logic [7:0] REG_LOW = 8'h04;
   localparam logic [7:0] REG_HIGH = 8'h05;

   // ----------------------------------------------------------------
   // configuration field positions (upper byte, so byte writes reach them)
   // ----------------------------------------------------------------
   localparam int CFG_SHDN = 8;
   localparam int CFG_INTMODE = 9;
   localparam int CFG_WPOL = 10;
   localparam int CFG_QUEUE_LO = 11;
   localparam int CFG_QUEUE_HI = 12;
   localparam int CFG_OPOL = 13;
   localparam int CFG_TODIS = 15;
   localparam logic [15:0] CFG_MASK = 16'hbf00;
   localparam logic [15:0] THR_MASK = 16'hff80;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [15:0] TEMP_RST = 16'h0000;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] HYST_RST = 16'h0100;
   localparam logic [15:0] MAX_RST = 16'h2800;
   localparam logic [15:0] LOW_RST = 16'h0500;
   localparam logic [15:0] HIGH_RST = 16'h2000;
   localparam logic [15:0] RDATA_RST = 16'h0000;

   // fixed upper bits of the slave address; the two low bits come from pins
   localparam logic [4:0] ADDR_BASE = 5'h12;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int LINK_PERIOD_NS = 160;
   localparam int TIMEOUT_NS = 25000000;
   localparam int TIMEOUT_CYC = (TIMEOUT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

   // ----------------------------------------------------------------
   // two-wire slave states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_CMD, LK_WDAT, LK_RDAT} tmm_link_state_t;

endpackage : tmm_pkg

// ---- testbench/tb_tmm_monitor.sv ----
// self-checking bench for the temperature threshold monitor
`timescale 1ns/1ps
module tb_tmm_monitor;
   import tmm_pkg::*;
   localparam logic [6:0] DEV = {ADDR_BASE, 2'b01};
   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset = 1'b1;
   logic [12:0] ts = '0;
   logic tv = 1'b0;
   logic sda_oe, ce, wf_oe, om_oe, ak;
   wire scl, sda;
   logic [15:0] rv;
   logic [8:0] q;
   logic [15:0] dflt [7] = '{TEMP_RST, CFG_RST, HYST_RST, MAX_RST, LOW_RST, HIGH_RST, 16'h0000};
   // sample, over-max oe, window oe
   logic [14:0] seq [7] = '{{13'd575, 2'b00}, {13'd576, 2'b10}, {13'd528, 2'b10}, {13'd527, 2'b00},
      {13'd304, 2'b01}, {13'd352, 2'b01}, {13'd368, 2'b00}};
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   initial forever #25 sys_clk = ~sys_clk;
   // link clock offset so the two share no phase
   initial begin
      #37;
      forever #80 link_clk = ~link_clk;
   end
   tmm_monitor #(.TIMEOUT_CYCLES(200)) i_tmm_monitor (.sys_clk(sys_clk), .reset(reset), .link_clk(link_clk),
      .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_select_bit0(1'b1),
      .addr_select_bit1(1'b0), .temp_sample(ts), .temp_valid(tv), .conv_enable(ce),
      .window_fault_out(), .window_fault_oe(wf_oe), .over_maximum_out(), .over_maximum_oe(om_oe));
   tmm_host i_host (.clk(sys_clk), .dut_oe(sda_oe), .scl(scl), .sda(sda));
   task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // one result pulse, then wait out the two-cycle fault latency
   task automatic conv(input logic [12:0] s);
      ts <= s;
      tv <= 1'b1;
      @(posedge sys_clk);
      tv <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : conv
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // a hang counts as a mismatch
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      // longer than eight cycles so seven link edges fall in reset
      repeat (24) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (40) @(posedge sys_clk);
      check("fault_rst", {om_oe, wf_oe, ce}, 3'b001);
      for (int r = 0; r < 7; r++) begin
         i_host.rd(DEV, 8'(r), 1, rv);
         check("reg_rst", rv, dflt[r]);
      end
      $display("test defaults done");
      i_host.wr(DEV, REG_MAX, 16'h11ff, 2, ak);
      check("addr_ack", ak, 1'b1);
      i_host.wr(DEV, REG_LOW, 16'h0a00, 1, ak);
      i_host.wr({ADDR_BASE, 2'b10}, REG_HYST, 16'h7f00, 1, ak);
      check("addr_nack", ak, 1'b0);
      i_host.rd(DEV, REG_MAX, 2, rv);
      check("max", rv, 16'h1180);
      i_host.rd(DEV, REG_LOW, 1, rv);
      check("low", rv, 16'h0a00);
      $display("test registers done");
      foreach (seq[i]) begin
         conv(seq[i][14:2]);
         check("faults", {om_oe, wf_oe}, seq[i][1:0]);
      end
      i_host.rd(DEV, REG_TEMP, 2, rv);
      check("temp", rv, {13'd368, 3'b000});
      $display("test comparator done");
      i_host.wr(DEV, REG_CFG, 16'h2600, 1, ak);
      conv(13'd368);
      check("pol_idle", {om_oe, wf_oe}, 2'b11);
      conv(13'd1120);
      check("int_set", {om_oe, wf_oe}, 2'b00);
      i_host.rd(DEV, REG_TEMP, 1, rv);
      check("int_clr", wf_oe, 1'b1);
      conv(13'd976);
      check("int_again", wf_oe, 1'b0);
      $display("test interrupt done");
      i_host.wr(DEV, REG_CFG, 16'h0100, 1, ak);
      check("conv_off", ce, 1'b0);
      conv(13'd0);
      i_host.rd(DEV, REG_TEMP, 2, rv);
      check("temp_kept", rv, {13'd976, 3'b000});
      i_host.rd(DEV, REG_CFG, 2, rv);
      check("cfg", rv, 16'h0100);
      $display("test shutdown done");
      // host stalls with the clock low after the address; the engine must drop it
      i_host.cond(1'b1);
      i_host.xb({DEV, 2'b01}, q);
      repeat (800) @(posedge sys_clk);
      i_host.xb(9'h1ff, q);
      check("to_drop", q[0], 1'b1);
      i_host.cond(1'b0);
      // timeout off, queue of two conversions, comparator mode, default polarity
      i_host.wr(DEV, REG_CFG, 16'h8800, 1, ak);
      conv(13'd1120);
      check("queue_wait", wf_oe, 1'b0);
      conv(13'd1120);
      check("queue_full", wf_oe, 1'b1);
      i_host.cond(1'b1);
      i_host.xb({DEV, 2'b01}, q);
      repeat (800) @(posedge sys_clk);
      i_host.xb(9'h1ff, q);
      check("to_off", q[0], 1'b0);
      i_host.cond(1'b0);
      $display("test timeout done");
      wrap_up();
   end
endmodule : tb_tmm_monitor

// ---- testbench/tmm_host.sv ----
// two-wire host model; sda has a pull-up
`timescale 1ns/1ps
module tmm_host (
   // clock
   input wire logic clk,
   // bus wires
   input wire logic dut_oe,
   output logic scl,
   output wire logic sda
);
   logic pull = 1'b0;
   initial scl = 1'b1;
   // a released line rises through the pull-up
   assign sda = ~(pull | dut_oe);
   // quarter bit; 26 cycles keeps 16 link cycles per half period
   task automatic hw(input int n);
      repeat (26 * n) @(posedge clk);
   endtask : hw
   // sda moves only mid-low, so no false start or stop
   task automatic bit_io(input logic b, output logic r);
      hw(1);
      pull <= ~b;
      hw(1);
      scl <= 1'b1;
      hw(2);
      r = sda;
      scl <= 1'b0;
   endtask : bit_io
   // start when s is high, stop when low
   task automatic cond(input logic s);
      hw(1);
      pull <= ~s;
      hw(1);
      scl <= 1'b1;
      hw(2);
      pull <= s;
      hw(2);
      if (s) scl <= 1'b0;
   endtask : cond
   task automatic xb(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
   endtask : xb
   // pointer then n data bytes; ak is the address ack
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input int n, output logic ak);
      logic [8:0] q;
      cond(1'b1);
      xb({a, 2'b01}, q);
      ak = ~q[0];
      xb({p, 1'b1}, q);
      if (n > 0) xb({d[15:8], 1'b1}, q);
      if (n > 1) xb({d[7:0], 1'b1}, q);
      cond(1'b0);
   endtask : wr
   // pointer, repeated start, n bytes read, last one refused
   task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n, output logic [15:0] d);
      logic [8:0] q;
      d = '0;
      cond(1'b1);
      xb({a, 2'b01}, q);
      xb({p, 1'b1}, q);
      cond(1'b1);
      xb({a, 2'b11}, q);
      xb({8'hff, n < 2}, q);
      d[15:8] = q[8:1];
      if (n > 1) xb(9'h1ff, q);
      if (n > 1) d[7:0] = q[8:1];
      cond(1'b0);
   endtask : rd
endmodule : tmm_host

// ---- verilog/tmm_monitor.sv ----
// temperature threshold monitor: two-wire register slave, limit compare, fault pins
`timescale 1ns/1ps
//
// Function
// - temperature register at 0x00, sixteenth-degree steps
// - four threshold registers, written and read back
// - configuration register at 0x01 holding all controls
// - timeout control bit high disables bus timeout
// - fault queue counts consecutive out-of-limit conversions
// - each fault pin polarity from own bit
// - over-maximum sets above max, clears below max-hyst
// - comparator mode: fault while outside the window
// - comparator mode: release inside limits minus hysteresis
// - interrupt mode: latch on crossing, clear on temperature read
// - interrupt mode: relatch on hysteresis return crossing
// - shutdown stops conversions, registers kept
// - one of four slave addresses answered
// - byte and word reads and writes supported
// - only integer degrees compared against limits
// - default polarity drives window fault low
// - address-select pins form address low bits
// - stalled bus released by timeout
module tmm_monitor
   import tmm_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   // system clock domain
   input wire logic sys_clk,
   input wire logic reset,
   // link oversampling clock
   input wire logic link_clk,
   // two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // address select straps
   input wire logic addr_select_bit0,
   input wire logic addr_select_bit1,
   // conversion front end
   input wire logic [12:0] temp_sample,
   input wire logic temp_valid,
   output logic conv_enable,
   // open-drain fault pins
   output logic window_fault_out,
   output logic window_fault_oe,
   output logic over_maximum_out,
   output logic over_maximum_oe
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   localparam logic [23:0] TO_LAST = 24'(TIMEOUT_CYCLES - 1);

   logic link_rst_m, link_rst;
   logic [5:0] ls;
   logic scl_s, sda_s, rd_ack_s, to_dis;
   logic [1:0] asel;
   logic scl_q, sda_q, rd_ack_q;
   logic start, stop, scl_rise, scl_fall, byte_end, ack_end, addr_hit, timeout;
   tmm_link_state_t state;
   logic [3:0] bit_cnt;
   logic ack_slot, ack_drive, byte_idx, host_nack;
   logic [7:0] shreg, tx, ptr, wr_hi, wr_lo;
   logic [1:0] wr_cnt;
   logic wr_tog, rd_tog;
   logic [7:0] wr_ptr_x, rd_ptr_x;
   logic [15:0] wr_word_x, rd_word;
   logic [23:0] to_cnt;
   logic next_sda_oe;

   logic [1:0] ss;
   logic wr_q, rd_q, wr_evt, rd_evt;
   logic [15:0] temp_reading, sensor_configuration, hysteresis_threshold;
   logic [15:0] maximum_threshold, low_threshold, high_threshold;
   logic [15:0] rd_data_sys;
   logic rd_ack_tog;
   logic conv;
   logic signed [9:0] t, hy;
   logic t_hi, t_lo, hi_rel, lo_rel, max_set, max_rel, out_lim, qok;
   logic [2:0] qcnt, next_qcnt;
   logic hi_state, lo_state, next_hi, next_lo, latch, over_max, window_active;
   logic latch_set, latch_clr;

   // integer degrees of a left-justified word, sign extended for subtraction
   function automatic logic signed [9:0] deg(input logic [15:0] w);
      return $signed({w[15], w[15:7]});
   endfunction : deg

   // consecutive out-of-limit conversions needed before a fault
   function automatic logic [2:0] queue_depth(input logic [1:0] code);
      case (code)
         2'h0: return 3'h1;
         2'h1: return 3'h2;
         2'h2: return 3'h4;
         default: return 3'h6;
      endcase
   endfunction : queue_depth

   // ----------------------------------------------------------------
   // link domain: reset and pin synchronisation
   // ----------------------------------------------------------------
   // reset is carried into the link domain by two flops
   always_ff @(posedge link_clk) begin
      link_rst_m <= reset;
      link_rst <= link_rst_m;
   end

   tmm_pin_sync #(.WIDTH(6), .INIT(6'h30)) u_link_sync (
      .clk(link_clk),
      .rst(link_rst),
      .din({scl_in, sda_in, addr_select_bit1, addr_select_bit0, rd_ack_tog, sensor_configuration[CFG_TODIS]}),
      .dout(ls)
   );

   assign scl_s = ls[5];
   assign sda_s = ls[4];
   assign asel = ls[3:2]; // straps read continuously
   assign rd_ack_s = ls[1];
   assign to_dis = ls[0];

   // history for edge and condition detection
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rd_ack_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         rd_ack_q <= rd_ack_s;
      end
   end

   assign start = scl_s & scl_q & sda_q & ~sda_s;
   assign stop = scl_s & scl_q & ~sda_q & sda_s;
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign byte_end = scl_fall & (bit_cnt == 4'h8) & ~ack_slot;
   assign ack_end = scl_fall & ack_slot;
   assign addr_hit = (shreg[7:1] == {ADDR_BASE, asel});

   // ----------------------------------------------------------------
   // link domain: bus timeout
   // ----------------------------------------------------------------
   // counts clock-low time; saturates one past the limit so it fires once
   always_ff @(posedge link_clk) begin
      if (link_rst | scl_s | (state == LK_IDLE)) begin
         to_cnt <= 24'h000000;
      end else if (to_cnt != TO_LAST + 24'h000001) begin
         to_cnt <= to_cnt + 24'h000001;
      end
   end

   assign timeout = ~to_dis & (to_cnt == TO_LAST);

   // ----------------------------------------------------------------
   // link domain: slave byte engine
   // ----------------------------------------------------------------
   // a stop, a timeout or a start always resynchronises the engine
   always_ff @(posedge link_clk) begin
      if (link_rst | timeout | stop) begin
         state <= LK_IDLE;
         bit_cnt <= 4'h0;
         ack_slot <= 1'b0;
         ack_drive <= 1'b0;
         byte_idx <= 1'b0;
         wr_cnt <= 2'h0;
         host_nack <= 1'b0;
         shreg <= 8'h00;
         tx <= 8'hff;
         ptr <= 8'h00;
         wr_hi <= 8'h00;
         wr_lo <= 8'h00;
      end else if (start) begin
         state <= LK_ADDR;
         bit_cnt <= 4'h0;
         ack_slot <= 1'b0;
         ack_drive <= 1'b0;
         byte_idx <= 1'b0;
         wr_cnt <= 2'h0;
      end else if (state != LK_IDLE) begin
         if (scl_rise & (bit_cnt < 4'h8)) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
         end
         if (scl_rise & ack_slot & ~ack_drive) begin
            host_nack <= sda_s;
         end
         // outgoing bits only change while the clock is low
         if (scl_fall & (state == LK_RDAT) & (bit_cnt != 4'h0) & (bit_cnt < 4'h8)) begin
            tx <= {tx[6:0], 1'b1};
         end
         if (byte_end) begin
            case (state)
               LK_ADDR: begin
                  if (addr_hit) begin
                     ack_slot <= 1'b1;
                     ack_drive <= 1'b1;
                     state <= shreg[0] ? LK_RDAT : LK_CMD;
                  end else begin
                     state <= LK_IDLE;
                  end
               end
               LK_CMD: begin
                  ptr <= shreg;
                  ack_slot <= 1'b1;
                  ack_drive <= 1'b1;
                  state <= LK_WDAT;
               end
               LK_WDAT: begin
                  ack_slot <= 1'b1;
                  ack_drive <= 1'b1;
                  if (wr_cnt == 2'h0) begin
                     wr_hi <= shreg;
                  end else begin
                     wr_lo <= shreg;
                  end
                  if (wr_cnt != 2'h2) begin
                     wr_cnt <= wr_cnt + 2'h1;
                  end
               end
               LK_RDAT: begin
                  ack_slot <= 1'b1;
               end
               default: begin
                  state <= LK_IDLE;
               end
            endcase
         end
         if (ack_end) begin
            ack_slot <= 1'b0;
            ack_drive <= 1'b0;
            bit_cnt <= 4'h0;
            if (state == LK_RDAT) begin
               if (host_nack & ~ack_drive) begin
                  state <= LK_IDLE;
               end else begin
                  tx <= byte_idx ? rd_word[7:0] : rd_word[15:8];
                  byte_idx <= ~byte_idx;
               end
            end
         end
      end
   end

   // pin pulls low for our acknowledge and for zero data bits
   assign next_sda_oe = ack_drive | ((state == LK_RDAT) & ~ack_slot & ~tx[7]);

   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= next_sda_oe;
      end
   end

   assign sda_out = 1'b0;

   // ----------------------------------------------------------------
   // link domain: requests toward the register file
   // ----------------------------------------------------------------
   // write words are held stable after the toggle, so the far side may read them directly
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         wr_tog <= 1'b0;
         wr_ptr_x <= 8'h00;
         wr_word_x <= 16'h0000;
      end else if ((start | stop) & (state == LK_WDAT) & (wr_cnt != 2'h0)) begin
         wr_tog <= ~wr_tog;
         wr_ptr_x <= ptr;
         wr_word_x <= {wr_hi, (wr_cnt == 2'h1) ? 8'h00 : wr_lo};
      end
   end

   // read pointer is the command byte of this transfer, 0x00 if none since a stop or timeout; the answer returns well inside the ack slot
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         rd_tog <= 1'b0;
         rd_ptr_x <= 8'h00;
         rd_word <= RDATA_RST;
      end else begin
         if (byte_end & (state == LK_ADDR) & addr_hit & shreg[0]) begin
            rd_tog <= ~rd_tog;
            rd_ptr_x <= ptr;
         end
         if (rd_ack_s != rd_ack_q) begin
            rd_word <= rd_data_sys;
         end
      end
   end

   // ----------------------------------------------------------------
   // system domain: request crossing and register file
   // ----------------------------------------------------------------
   tmm_pin_sync #(.WIDTH(2), .INIT(2'h0)) u_sys_sync (
      .clk(sys_clk),
      .rst(reset),
      .din({wr_tog, rd_tog}),
      .dout(ss)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         wr_q <= ss[1];
         rd_q <= ss[0];
      end
   end

   assign wr_evt = ss[1] ^ wr_q;
   assign rd_evt = ss[0] ^ rd_q;
   assign conv = temp_valid & ~sensor_configuration[CFG_SHDN];
   assign conv_enable = ~sensor_configuration[CFG_SHDN];

   // writable registers; the temperature word ignores writes
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sensor_configuration <= CFG_RST;
         hysteresis_threshold <= HYST_RST;
         maximum_threshold <= MAX_RST;
         low_threshold <= LOW_RST;
         high_threshold <= HIGH_RST;
      end else if (wr_evt) begin
         case (wr_ptr_x)
            REG_CFG: sensor_configuration <= wr_word_x & CFG_MASK;
            REG_HYST: hysteresis_threshold <= wr_word_x & THR_MASK;
            REG_MAX: maximum_threshold <= wr_word_x & THR_MASK;
            REG_LOW: low_threshold <= wr_word_x & THR_MASK;
            REG_HIGH: high_threshold <= wr_word_x & THR_MASK;
            default: ;
         endcase
      end
   end

   // conversion result stored left-justified
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         temp_reading <= TEMP_RST;
      end else if (conv) begin
         temp_reading <= {temp_sample, 3'h0};
      end
   end

   // read answer; unmapped pointers read as zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rd_data_sys <= RDATA_RST;
         rd_ack_tog <= 1'b0;
      end else if (rd_evt) begin
         rd_ack_tog <= ~rd_ack_tog;
         case (rd_ptr_x)
            REG_TEMP: rd_data_sys <= temp_reading;
            REG_CFG: rd_data_sys <= sensor_configuration;
            REG_HYST: rd_data_sys <= hysteresis_threshold;
            REG_MAX: rd_data_sys <= maximum_threshold;
            REG_LOW: rd_data_sys <= low_threshold;
            REG_HIGH: rd_data_sys <= high_threshold;
            default: rd_data_sys <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // system domain: limit comparison
   // ----------------------------------------------------------------
   // fraction bits are dropped before any compare
   assign t = $signed({temp_sample[12], temp_sample[12:4]});
   assign hy = deg(hysteresis_threshold);
   assign t_hi = t > deg(high_threshold);
   assign t_lo = t < deg(low_threshold);
   assign hi_rel = t < (deg(high_threshold) - hy);
   assign lo_rel = t > (deg(low_threshold) + hy);
   assign max_set = t > deg(maximum_threshold);
   assign max_rel = t < (deg(maximum_threshold) - hy);
   assign out_lim = t_hi | t_lo;
   assign next_qcnt = out_lim ? ((qcnt == 3'h7) ? 3'h7 : qcnt + 3'h1) : 3'h0;
   assign qok = out_lim & (next_qcnt >= queue_depth(sensor_configuration[CFG_QUEUE_HI:CFG_QUEUE_LO]));
   assign next_hi = hi_state ? ~hi_rel : (qok & t_hi);
   assign next_lo = lo_state ? ~lo_rel : (qok & t_lo);

   // queue counter advances only on accepted conversions
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         qcnt <= 3'h0;
      end else if (conv) begin
         qcnt <= next_qcnt;
      end
   end

   // window side states carry the hysteresis for both modes
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hi_state <= 1'b0;
         lo_state <= 1'b0;
      end else if (conv) begin
         hi_state <= next_hi;
         lo_state <= next_lo;
      end
   end

   // every side change is an interrupt event; a set in the clearing cycle wins
   assign latch_set = conv & sensor_configuration[CFG_INTMODE] & ((next_hi != hi_state) | (next_lo != lo_state));
   assign latch_clr = rd_evt & (rd_ptr_x == REG_TEMP);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         latch <= 1'b0;
      end else if (latch_set) begin
         latch <= 1'b1;
      end else if (latch_clr) begin
         latch <= 1'b0;
      end
   end

   // over-maximum with its own hysteresis, no queue
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         over_max <= 1'b0;
      end else if (conv) begin
         over_max <= over_max ? ~max_rel : max_set;
      end
   end

   assign window_active = sensor_configuration[CFG_INTMODE] ? latch : (hi_state | lo_state);

   // ----------------------------------------------------------------
   // fault pins
   // ----------------------------------------------------------------
   // open drain: with polarity zero the pin is pulled low while active
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         window_fault_oe <= 1'b0;
         over_maximum_oe <= 1'b0;
      end else begin
         window_fault_oe <= window_active ^ sensor_configuration[CFG_WPOL];
         over_maximum_oe <= over_max ^ sensor_configuration[CFG_OPOL];
      end
   end

   assign window_fault_out = 1'b0;
   assign over_maximum_out = 1'b0;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_temp_capture: assert property (@(posedge sys_clk) disable iff (reset)
      conv |=> temp_reading == {$past(temp_sample), 3'h0}) else $error("temperature not captured");
   a_thresh_write: assert property (@(posedge sys_clk) disable iff (reset)
      wr_evt && wr_ptr_x == REG_MAX |=> maximum_threshold == ($past(wr_word_x) & THR_MASK))
      else $error("maximum threshold write lost");
   a_shutdown_hold: assert property (@(posedge sys_clk) disable iff (reset)
      sensor_configuration[CFG_SHDN] && temp_valid |=> $stable(temp_reading)) else $error("conversion in shutdown");
   a_over_max_set: assert property (@(posedge sys_clk) disable iff (reset)
      conv && max_set |=> over_max ##1 over_maximum_oe == !sensor_configuration[CFG_OPOL])
      else $error("over maximum not raised");
   a_over_max_keep: assert property (@(posedge sys_clk) disable iff (reset)
      over_max && !(conv && max_rel) |=> over_max) else $error("over maximum dropped early");
   a_queue_gate: assert property (@(posedge sys_clk) disable iff (reset)
      conv && !hi_state && t_hi && next_qcnt < queue_depth(sensor_configuration[CFG_QUEUE_HI:CFG_QUEUE_LO])
      |=> !hi_state) else $error("fault before queue filled");
   a_window_pol: assert property (@(posedge sys_clk) disable iff (reset)
      ##1 window_fault_oe == ($past(window_active) ^ $past(sensor_configuration[CFG_WPOL])))
      else $error("window fault polarity wrong");
   a_latch_clear: assert property (@(posedge sys_clk) disable iff (reset)
      latch_clr && !latch_set |=> !latch) else $error("interrupt latch not cleared");
   a_comp_window: assert property (@(posedge sys_clk) disable iff (reset)
      !sensor_configuration[CFG_INTMODE] |-> window_active == (hi_state || lo_state))
      else $error("comparator window mismatch");
   a_timeout_free: assert property (@(posedge link_clk) disable iff (link_rst)
      timeout |=> state == LK_IDLE && !ack_drive) else $error("bus not released on timeout");

   c_over_max: cover property (@(posedge sys_clk) disable iff (reset) $rose(over_max));
   c_latch: cover property (@(posedge sys_clk) disable iff (reset) latch_set ##[1:1000] latch_clr);
   c_read: cover property (@(posedge sys_clk) disable iff (reset) rd_evt && rd_ptr_x == REG_TEMP);
   c_write: cover property (@(posedge sys_clk) disable iff (reset) wr_evt && wr_ptr_x == REG_CFG);

endmodule : tmm_monitor

// ---- verilog/tmm_pin_sync.sv ----
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module tmm_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous input and filtered result
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   // stage one feeds only stage two, so metastability never reaches a gate
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a bit that still disagrees keeps its old value, which filters one-cycle glitches
   always_ff @(posedge clk) begin
      if (rst) begin
         dout <= INIT;
      end else begin
         dout <= (s2 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
      end
   end

endmodule : tmm_pin_sync
